/* File: src/fbh_ctrl.sv */
// flash bus host: runs single read, write and protect cycles on a parallel flash
// assumes an AXI4-Lite master that keeps one write and one read outstanding at most
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fbh_regs.svh"
module fbh_ctrl import fbh_pkg::*; (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // flash pins
  output logic [17:0]      address_lines_out,
  input  wire logic [15:0] data_lines_in,
  output logic [15:0]      data_lines_out,
  output logic [15:0]      data_lines_oe_n_out,
  output logic             chip_sel_n_out,
  output logic             out_gate_n_out,
  output logic             wr_strobe_n_out,
  output logic             flash_reset_n_out,
  output logic             elevated_select_voltage_out,
  output logic             width_sel_out,
  input  wire logic        ready_busy_n_in
);
  localparam logic [3:0] SETUP_CYC = 4'(`FBH_CYC(`FBH_SETUP_NS));
  localparam logic [3:0] RD_CYC    = 4'(`FBH_CYC(`FBH_RD_ACC_NS) + `FBH_SYNC_CYC);
  localparam logic [3:0] WR_CYC    = 4'(`FBH_CYC(`FBH_WR_PULSE_NS));
  localparam logic [3:0] HOLD_CYC  = 4'(`FBH_CYC(`FBH_HOLD_NS));

  fbh_state_t  state_q, state_d;
  fbh_op_t     op_q;
  logic        byte_q, frst_q, tmpu_q, done_q;
  logic [18:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [15:0] dq_meta_q, dq_sync_q;
  logic [1:0]  rb_q;
  logic        tmr_done, tmr_load;
  logic [3:0]  tmr_count;
  logic        wr_fire, go, is_rd, busy;

  // pin inputs cross two flops before any use
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dq_meta_q <= 16'h0000;
      dq_sync_q <= 16'h0000;
      rb_q      <= 2'h0;
    end else begin
      dq_meta_q <= data_lines_in;
      dq_sync_q <= dq_meta_q;
      rb_q      <= {rb_q[0], ready_busy_n_in};
    end
  end

  // register writes
  assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out;
  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out  = wr_fire;
  assign busy = (state_q != FBH_IDLE);
  // a start while the flash is held in reset is dropped
  assign go = wr_fire && (s_axi_awaddr_in == `FBH_CTRL_OFS) && s_axi_wstrb_in[0]
              && s_axi_wdata_in[`FBH_CTRL_GO] && !busy && !frst_q;
  assign is_rd = (op_q == FBH_OP_READ);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_q    <= FBH_OP_READ;
      byte_q  <= 1'b0;
      frst_q  <= 1'b0;
      tmpu_q  <= 1'b0;
      addr_q  <= 19'h00000;
      wdata_q <= 16'h0000;
    end else if (wr_fire && s_axi_wstrb_in[0] && !busy) begin
      case (s_axi_awaddr_in)
        `FBH_CTRL_OFS: begin
          op_q   <= fbh_op_t'(s_axi_wdata_in[`FBH_CTRL_OP_HI:`FBH_CTRL_OP_LO]);
          byte_q <= s_axi_wdata_in[`FBH_CTRL_BYTE];
          frst_q <= s_axi_wdata_in[`FBH_CTRL_FRST];
          tmpu_q <= s_axi_wdata_in[`FBH_CTRL_TMPU];
        end
        `FBH_ADDR_OFS:  addr_q  <= s_axi_wdata_in[18:0];
        `FBH_WDATA_OFS: wdata_q <= s_axi_wdata_in[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `FBH_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (s_axi_awaddr_in == `FBH_RDATA_OFS ||
                           s_axi_awaddr_in > `FBH_STAT_OFS) ? `FBH_RESP_SLVERR : `FBH_RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // register reads
  assign s_axi_arready_out = !s_axi_rvalid_out;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= `FBH_RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= `FBH_RESP_OKAY;
      case (s_axi_araddr_in)
        `FBH_CTRL_OFS:  s_axi_rdata_out <= {26'h0, tmpu_q, frst_q, byte_q, op_q, 1'b0};
        `FBH_ADDR_OFS:  s_axi_rdata_out <= {13'h0, addr_q};
        `FBH_WDATA_OFS: s_axi_rdata_out <= {16'h0, wdata_q};
        `FBH_RDATA_OFS: s_axi_rdata_out <= {16'h0, rdata_q};
        `FBH_STAT_OFS:  s_axi_rdata_out <= {29'h0, done_q, rb_q[1], busy};
        default: begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= `FBH_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // cycle sequencer
  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = SETUP_CYC;
    case (state_q)
      FBH_IDLE: if (go) begin
        state_d  = FBH_SETUP;
        tmr_load = 1'b1;
      end
      FBH_SETUP: if (tmr_done) begin
        state_d   = FBH_STROBE;
        tmr_load  = 1'b1;
        tmr_count = is_rd ? RD_CYC : WR_CYC;
      end
      FBH_STROBE: if (tmr_done) begin
        state_d   = FBH_HOLD;
        tmr_load  = 1'b1;
        tmr_count = HOLD_CYC;
      end
      FBH_HOLD: if (tmr_done) state_d = FBH_IDLE;
      default: state_d = FBH_IDLE;
    endcase
  end

  fbh_timer u_timer (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .done_out    (tmr_done)
  );

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= FBH_IDLE;
    end else if (frst_q) begin
      state_q <= FBH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // read data is taken at the end of hold, once the synchroniser has covered the access time
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 16'h0000;
    end else if (state_q == FBH_HOLD && tmr_done && is_rd) begin
      rdata_q <= byte_q ? {8'h00, dq_sync_q[7:0]} : dq_sync_q;
    end
  end

  // done is sticky; a completion in the clearing cycle wins
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_q <= 1'b0;
    end else if (state_q == FBH_HOLD && tmr_done) begin
      done_q <= 1'b1;
    end else if (wr_fire && s_axi_awaddr_in == `FBH_STAT_OFS && s_axi_wstrb_in[0]
                 && s_axi_wdata_in[`FBH_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // pin drive, all from flops; pins follow the registered state so that address,
  // width and op fields loaded with go settle a cycle before any strobe falls
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chip_sel_n_out              <= 1'b1;
      out_gate_n_out              <= 1'b1;
      wr_strobe_n_out             <= 1'b1;
      flash_reset_n_out           <= 1'b1;
      elevated_select_voltage_out <= 1'b0;
      width_sel_out               <= 1'b1;
      address_lines_out           <= 18'h00000;
      data_lines_out              <= 16'h0000;
      data_lines_oe_n_out         <= 16'hFFFF;
    end else begin
      // chip select idles high for standby between cycles
      chip_sel_n_out    <= (state_q == FBH_IDLE) || frst_q;
      out_gate_n_out    <= !(state_q == FBH_STROBE && is_rd && !frst_q);
      wr_strobe_n_out   <= !(state_q == FBH_STROBE && !is_rd && !frst_q);
      flash_reset_n_out <= !frst_q;
      elevated_select_voltage_out <= tmpu_q ||
                         (state_q != FBH_IDLE && op_q[1] && !frst_q);
      width_sel_out     <= !byte_q;
      address_lines_out <= byte_q ? addr_q[18:1] : addr_q[17:0];
      if (op_q[1]) begin
        address_lines_out[`FBH_A6] <= op_q[0];
        address_lines_out[`FBH_A1] <= 1'b1;
        address_lines_out[`FBH_A0] <= 1'b0;
      end
      data_lines_out <= wdata_q;
      if (byte_q) begin
        data_lines_out[`FBH_MSB] <= addr_q[0];
      end
      // never drive while the flash may drive; held one phase past the strobe
      data_lines_oe_n_out <= 16'hFFFF;
      if (state_q != FBH_IDLE && !is_rd && !frst_q) begin
        data_lines_oe_n_out <= byte_q ? 16'hFF00 : 16'h0000;
      end
      if (byte_q && !frst_q) begin
        data_lines_oe_n_out[`FBH_MSB] <= 1'b0;
      end
    end
  end

  // checks
  sequence s_wr_pulse;
    !wr_strobe_n_out [*2] ##1 wr_strobe_n_out;
  endsequence
  sequence s_rd_pulse;
    !out_gate_n_out [*7] ##1 out_gate_n_out;
  endsequence

  a_read_levels: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !out_gate_n_out |-> !chip_sel_n_out && wr_strobe_n_out)
    else $error("read strobe without select or with write strobe");
  a_write_levels: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !wr_strobe_n_out |-> !chip_sel_n_out && out_gate_n_out)
    else $error("write strobe with output gate low or no select");
  a_no_contention: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !out_gate_n_out |-> (data_lines_oe_n_out[14:0] == 15'h7FFF))
    else $error("host drives data while flash output gate is low");
  // the low-address lane is registered, so it trails an address write by one cycle
  a_byte_lanes: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !width_sel_out && flash_reset_n_out |-> (data_lines_oe_n_out[14:8] == 7'h7F)
      && !data_lines_oe_n_out[`FBH_MSB] && data_lines_out[`FBH_MSB] == $past(addr_q[0]))
    else $error("byte mode lanes wrong");
  a_wr_width: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(wr_strobe_n_out) |-> s_wr_pulse)
    else $error("write strobe width not two cycles");
  a_rd_width: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(out_gate_n_out) |-> s_rd_pulse)
    else $error("output gate width not seven cycles");
  a_data_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(wr_strobe_n_out) && !frst_q |-> !data_lines_oe_n_out[0]
      && $stable(data_lines_out) ##1 chip_sel_n_out)
    else $error("write data not held past strobe rise");
  a_protect_addr: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !wr_strobe_n_out && op_q[1] |-> elevated_select_voltage_out
      && address_lines_out[`FBH_A6] == op_q[0] && address_lines_out[`FBH_A1]
      && !address_lines_out[`FBH_A0])
    else $error("protect write address or voltage wrong");
  a_reset_quiet: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !flash_reset_n_out |-> chip_sel_n_out && out_gate_n_out && wr_strobe_n_out)
    else $error("cycle run while flash reset held");
  a_width_follow: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ##1 width_sel_out == !$past(byte_q))
    else $error("width select does not follow control");
endmodule : fbh_ctrl
`default_nettype wire

/* File: src/fbh_regs.svh */
// register offsets, fields and timing counts of the flash bus host
// assumes a 40 MHz core clock and a 32-bit AXI4-Lite register port
//
// How it works
// - read: chip select and output gate low, write strobe high; data returned.
// - write cycle: write strobe and chip select low, output gate held high.
// - shortcut program mode needs two write cycles instead of four.
// - protect: elevated select voltage, write with address bit6 low, bit1 high, bit0 low.
// - unprotect: same elevated write but address bit six high.
`ifndef FBH_REGS_SVH
`define FBH_REGS_SVH

`define FBH_CTRL_OFS      8'h00
`define FBH_ADDR_OFS      8'h04
`define FBH_WDATA_OFS     8'h08
`define FBH_RDATA_OFS     8'h0C
`define FBH_STAT_OFS      8'h10

`define FBH_CTRL_GO       0
`define FBH_CTRL_OP_LO    1
`define FBH_CTRL_OP_HI    2
`define FBH_CTRL_BYTE     3
`define FBH_CTRL_FRST     4
`define FBH_CTRL_TMPU     5

`define FBH_STAT_BUSY     0
`define FBH_STAT_RDY      1
`define FBH_STAT_DONE     2

`define FBH_A6            6
`define FBH_A1            1
`define FBH_A0            0
`define FBH_MSB           15

`define FBH_RESP_OKAY     2'h0
`define FBH_RESP_SLVERR   2'h2

`define FBH_CLK_MHZ       40
`define FBH_SETUP_NS      25
`define FBH_RD_ACC_NS     120
`define FBH_WR_PULSE_NS   50
`define FBH_HOLD_NS       25
`define FBH_SYNC_CYC      2
`define FBH_CYC(ns)       ((((ns) * `FBH_CLK_MHZ) + 999) / 1000)

`endif

/* File: src/fbh_pkg.sv */
// types shared by the flash bus host files
// assumes fbh_regs.svh for all numeric constants
package fbh_pkg;

  typedef enum logic [1:0] {
    FBH_IDLE   = 2'b00,
    FBH_SETUP  = 2'b01,
    FBH_STROBE = 2'b11,
    FBH_HOLD   = 2'b10
  } fbh_state_t;

  typedef enum logic [1:0] {
    FBH_OP_READ    = 2'b00,
    FBH_OP_WRITE   = 2'b01,
    FBH_OP_PROTECT = 2'b10,
    FBH_OP_UNPROT  = 2'b11
  } fbh_op_t;

endpackage : fbh_pkg

/* File: src/fbh_timer.sv */
// phase timer: after a load of n, done pulses in the n-th cycle
// assumes a load value of at least one
`timescale 1ns/1ps
`default_nettype none
module fbh_timer import fbh_pkg::*; (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // control
  input  wire logic       load_in,
  input  wire logic [3:0] count_in,
  output logic            done_out
);
  logic [3:0] cnt_q;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 4'h0;
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // not gated by load: the sequencer loads on done, and gating would close a loop
  assign done_out = (cnt_q == 4'h1);
endmodule : fbh_timer
`default_nettype wire

/* File: sim/fbh_flash_model.sv */
// behavioural parallel flash seen from the host side
// assumes the bench resolves the shared data lines from the host lane enables alone
`timescale 1ns/1ps
`default_nettype none
module fbh_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5E  // arbitrary value
) (
  // bus pins
  input  wire logic [17:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rst_n_in,
  input  wire logic        elev_in,
  input  wire logic        word_in,
  // status
  output logic             ready_busy_n_out
);
  logic [15:0] mem [0:255];
  logic [18:0] wa_q;
  logic        elev_q;
  logic        ident_q = 1'b0;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rd;
  wire sel = !ce_n_in && rst_n_in;
  wire drv = sel && !oe_n_in;
  wire wr  = sel && !we_n_in && oe_n_in;
  initial begin
    ready_busy_n_out = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
  end
  always @* begin
    rd = mem[addr_in[7:0]];
    if (ident_q) rd = {8'h00, ID_CODE};
    else if (!word_in) rd = {8'h00, dq_in[15] ? rd[15:8] : rd[7:0]};
  end
  // released lines show the inverse of what was last driven, never a stale copy
  always @(rd or drv) if (drv) last_q = rd;
  always @* for (int i = 0; i < 16; i++)
    dq_out[i] = (drv && (word_in || i < 8)) ? rd[i] : ~last_q[i];
  always @(posedge wr) begin
    wa_q   = {addr_in, dq_in[15]};
    elev_q = elev_in;
  end
  always @(negedge wr or negedge rst_n_in) begin
    if (!rst_n_in) ident_q = 1'b0;
    else if (!elev_q) begin
      if (dq_in[7:0] == 8'h90) ident_q = 1'b1;
      else if (dq_in[7:0] == 8'hF0) ident_q = 1'b0;
      else if (dq_in[7:0] == 8'h30) begin  // erase of the sector the address falls in
        for (int i = 0; i < 256; i++) if (i[7:4] == wa_q[8:5]) mem[i] = 16'hFFFF;
      end
      else if (word_in) mem[wa_q[8:1]] = dq_in;
      else if (wa_q[0]) mem[wa_q[8:1]][15:8] = dq_in[7:0];
      else mem[wa_q[8:1]][7:0] = dq_in[7:0];
    end
  end
  always @(negedge wr) begin
    ready_busy_n_out = 1'b0;
    #500;
    ready_busy_n_out = 1'b1;
  end
endmodule : fbh_flash_model
`default_nettype wire

/* File: sim/tb.sv */
// bench of the flash bus host: axi4-lite master on one side, flash model on the other
// assumes src/ is compiled first
`timescale 1ns/1ps
`default_nettype none
`include "fbh_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam logic [7:0] ID = 8'h5E;  // arbitrary value
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        awaddr = 8'h00;
  logic [7:0]        araddr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  wire logic         awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  wire logic [17:0]  fa;
  wire logic [15:0]  h_dq, h_oe_n, f_dq, dq_w;
  wire logic         ce_n, og_n, we_n, f_rst_n, elev, word, rb_n;
  logic [1:0]        rs;
  logic [31:0]       rv, st;
  int                fail_count = 0, n_compared = 0, cyc = 0;
  assign dq_w = (~h_oe_n & h_dq) | (h_oe_n & f_dq);
  initial forever #12.5 clk = ~clk;
  fbh_ctrl uut (
    .core_clk_in(clk), .reset_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .address_lines_out(fa), .data_lines_in(dq_w), .data_lines_out(h_dq),
    .data_lines_oe_n_out(h_oe_n), .chip_sel_n_out(ce_n), .out_gate_n_out(og_n),
    .wr_strobe_n_out(we_n), .flash_reset_n_out(f_rst_n),
    .elevated_select_voltage_out(elev), .width_sel_out(word), .ready_busy_n_in(rb_n));
  fbh_flash_model #(.ID_CODE(ID)) flash (
    .addr_in(fa), .dq_in(dq_w), .dq_out(f_dq), .ce_n_in(ce_n), .oe_n_in(og_n),
    .we_n_in(we_n), .rst_n_in(f_rst_n), .elev_in(elev), .word_in(word),
    .ready_busy_n_out(rb_n));
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // c is {byte mode, op}; returns the status word that showed completion
  task automatic op(input logic [2:0] c, input logic [18:0] a, input logic [15:0] d);
    wr(`FBH_ADDR_OFS, {13'h0, a}, rs);
    wr(`FBH_WDATA_OFS, {16'h0, d}, rs);
    wr(`FBH_CTRL_OFS, {28'h0, c, 1'b1}, rs);
    rv = 32'h0;
    while (rv[`FBH_STAT_DONE] !== 1'b1) rd(`FBH_STAT_OFS, rv, rs);
    st = rv;
    wr(`FBH_STAT_OFS, 32'h4, rs);
  endtask : op
  task automatic t_reset();
    `CHK("idle pins", 22'h3EFFFF, {ce_n, og_n, we_n, f_rst_n, word, elev, h_oe_n})
    rd(8'h14, rv, rs);
    `CHK("unmapped read", `FBH_RESP_SLVERR, rs)
    wr(`FBH_RDATA_OFS, 32'h1, rs);
    `CHK("rdata write", `FBH_RESP_SLVERR, rs)
  endtask : t_reset
  task automatic t_word();
    op(3'b001, 19'h12, 16'hA55A);
    `CHK("word program", 16'hA55A, flash.mem[8'h12])
    `CHK("write address", 18'h12, flash.wa_q[18:1])
    `CHK("done status", 2'b10, {st[`FBH_STAT_DONE], st[`FBH_STAT_BUSY]})
    rd(`FBH_STAT_OFS, rv, rs);
    `CHK("busy seen", 3'b000, rv[2:0])
    op(3'b000, 19'h12, 16'h0);
    rd(`FBH_RDATA_OFS, rv, rs);
    `CHK("word read", 16'hA55A, rv[15:0])
    repeat (30) @(posedge clk);
    rd(`FBH_STAT_OFS, rv, rs);
    `CHK("status idle", 3'b010, rv[2:0])
  endtask : t_word
  task automatic t_byte();
    op(3'b101, 19'h25, 16'h003C);
    `CHK("byte program", 16'h3C5A, flash.mem[8'h12])
    op(3'b100, 19'h24, 16'h0);
    rd(`FBH_RDATA_OFS, rv, rs);
    `CHK("byte read", 8'h5A, rv[7:0])
  endtask : t_byte
  task automatic t_prot();
    op(3'b010, 19'hFC3, 16'h0);
    `CHK("protect", 19'h40F82, {flash.elev_q, flash.wa_q[18:1]})
    op(3'b011, 19'hFC3, 16'h0);
    `CHK("unprotect", 19'h40FC2, {flash.elev_q, flash.wa_q[18:1]})
  endtask : t_prot
  task automatic t_ident();
    op(3'b001, 19'h555, 16'h0090);
    op(3'b000, 19'h0, 16'h0);
    rd(`FBH_RDATA_OFS, rv, rs);
    `CHK("id code", ID, rv[7:0])
    wr(`FBH_CTRL_OFS, 32'h10, rs);
    @(negedge clk);
    `CHK("reset pin", 1'b0, f_rst_n)
    wr(`FBH_CTRL_OFS, 32'h11, rs);
    repeat (4) @(posedge clk);
    `CHK("go in reset", 1'b1, ce_n)
    wr(`FBH_CTRL_OFS, 32'h0, rs);
    op(3'b000, 19'h12, 16'h0);
    rd(`FBH_RDATA_OFS, rv, rs);
    `CHK("array after reset", 16'h3C5A, rv[15:0])
    op(3'b001, 19'h12, 16'h0030);
    op(3'b000, 19'h12, 16'h0);
    rd(`FBH_RDATA_OFS, rv, rs);
    `CHK("sector erase", 16'hFFFF, rv[15:0])
  endtask : t_ident
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // pins are looked at mid-cycle, well away from the edge that launches them
  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
    if (rst_n && !og_n) `CHK("read strobes", 2'b10, {we_n, ce_n})
    if (rst_n && !og_n) `CHK("host float", 15'h7FFF, h_oe_n[14:0])
    if (rst_n && !we_n) `CHK("write strobes", 2'b10, {og_n, ce_n})
    if (rst_n && !we_n && word) `CHK("word lanes", 16'h0000, h_oe_n)
    if (rst_n && !word && f_rst_n) `CHK("byte lanes", 8'h7F, h_oe_n[15:8])
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_word();
    t_byte();
    t_prot();
    t_ident();
    finish_test();
  end
endmodule : tb
`default_nettype wire
